// ---- rtl/ctg_top.sv ----
// counter clock, gate, output and interrupt flag routing around two counters
//
// Functional notes
// - counter 0 clock is the time base, or field input 1 when selected.
// - counter 1 clock is the time base, or field input 3 when selected.
// - time base select picks 100 kHz, 10 kHz, 1 kHz or 100 Hz.
// - counter 0 gate is the software bit, or field input 0 when selected.
// - counter 1 gate is the software bit, or field input 2 when selected.
// - counter 0 output shows in status, and on field output 2 when routed.
// - counter 1 output shows in status, and on field output 3 when routed.
// - reading a flag gives 1 when an interrupt occurred, else 0.
// - writing 1 to a flag clears it; writing 0 does nothing.
// - a counter raises its interrupt only while its enable bit is 1.
// - cascade bit joins both counters into one 32-bit counter.
// - each counter is a 16-bit down counter loadable from 2 to 65535.
// - software gate bit gives the gate level when software gate is chosen.
// - output status bit shows the current counter output level.
`timescale 1ns/1ps
`default_nettype none
module ctg_top
    import ctg_pkg::*;
#(
    parameter int unsigned DIV_100K = CLK_HZ / TB_100K_HZ,
    parameter int unsigned DIV_10K = CLK_HZ / TB_10K_HZ,
    parameter int unsigned DIV_1K = CLK_HZ / TB_1K_HZ,
    parameter int unsigned DIV_100 = CLK_HZ / TB_100_HZ
) (
    input wire logic clk,
    input wire logic rst,
    input wire ctg_pkg::ctg_bus_t bus_req,
    output logic [7:0] rdata,
    input wire logic [3:0] isolated_input,
    output logic isolated_output_2,
    output logic isolated_output_3,
    output logic [1:0] counter_irq
);
    import ctg_pkg::*;

    localparam logic [7:0] A_CNT [2] = '{ADDR_CNT0, ADDR_CNT1};
    localparam logic [7:0] A_GATE [2] = '{ADDR_GATE0, ADDR_GATE1};
    localparam logic [7:0] A_SET [2] = '{ADDR_SET0, ADDR_SET1};
    localparam int unsigned F_BIT [2] = '{IRQ_F0_BIT, IRQ_F1_BIT};

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [PRE_W-1:0] div_last(input ctg_tb_t tb);
        logic [PRE_W-1:0] d;
        d = PRE_W'(DIV_100K - 1);
        unique case (tb)
            TB_100K: d = PRE_W'(DIV_100K - 1);
            TB_10K: d = PRE_W'(DIV_10K - 1);
            TB_1K: d = PRE_W'(DIV_1K - 1);
            TB_100: d = PRE_W'(DIV_100 - 1);
        endcase
        return d;
    endfunction

    function automatic logic [COUNT_W-1:0] clamp_count(input logic [COUNT_W-1:0] v);
        return (v < MIN_COUNT) ? MIN_COUNT : v;
    endfunction

    function automatic logic is_wr(input ctg_bus_t b, input logic [7:0] a);
        return b.wr && (b.addr == a);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state
    ctg_set_t set_reg [2];
    ctg_tb_t tb_reg;
    logic cascade_reg;
    logic [1:0] gate_bit_reg;
    logic [1:0] flag_reg;
    logic [1:0] rate_reg;
    ctg_ld_t ld_reg [2];
    logic [7:0] lo_byte_reg [2];
    logic [1:0] load_reg;
    logic [COUNT_W-1:0] load_val_reg [2];
    logic [1:0] rd_hi_reg;
    logic [PRE_W-1:0] presc_reg;
    logic tb_tick;
    logic [1:0] out_dly_reg;
    logic [1:0] iso_out_reg;
    logic [7:0] rdata_reg;

    logic [3:0] in_lvl;
    logic [3:0] in_rise;
    logic [1:0] tick;
    logic [1:0] gate;
    logic [1:0] cnt_out;
    logic [1:0] out_rise;
    logic [1:0] irq_set;
    logic [COUNT_W-1:0] cnt_val [2];

    ////////////////////////////////////////////////////////////////////////
    // field input synchronisers
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            ctg_in_sync u_sync (
                .clk(clk),
                .rst(rst),
                .pin(isolated_input[gi]),
                .level(in_lvl[gi]),
                .rise(in_rise[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // internal time base
    // a new rate restarts the prescaler so the first period is whole
    always_ff @(posedge clk) begin
        if (rst || is_wr(bus_req, ADDR_SET1)) begin
            presc_reg <= '0;
        end else if (presc_reg == div_last(tb_reg)) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + PRE_W'(1);
        end
    end

    assign tb_tick = (presc_reg == div_last(tb_reg));

    ////////////////////////////////////////////////////////////////////////
    // setting registers
    always_ff @(posedge clk) begin
        if (rst) begin
            set_reg[0] <= '0;
            set_reg[1] <= '0;
            tb_reg <= TB_100K;
            cascade_reg <= 1'b0;
        end else begin
            if (is_wr(bus_req, ADDR_SET0)) begin
                set_reg[0] <= ctg_set_t'(bus_req.wdata[3:0]);
            end
            if (is_wr(bus_req, ADDR_SET1)) begin
                set_reg[1] <= ctg_set_t'(bus_req.wdata[3:0]);
                tb_reg <= ctg_tb_t'(bus_req.wdata[TB_HIGH_BIT:TB_LOW_BIT]);
                cascade_reg <= bus_req.wdata[CASCADE_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            gate_bit_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (is_wr(bus_req, A_GATE[i])) begin
                    gate_bit_reg[i] <= bus_req.wdata[GATE_BIT];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock and gate selection
    assign tick[0] = set_reg[0].clock_select ? in_rise[1] : tb_tick;
    assign tick[1] = cascade_reg ? out_rise[0]
                   : (set_reg[1].clock_select ? in_rise[3] : tb_tick);
    assign gate[0] = set_reg[0].gate_select ? in_lvl[0] : gate_bit_reg[0];
    assign gate[1] = set_reg[1].gate_select ? in_lvl[2] : gate_bit_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // count loading: control write arms, then low and high bytes

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                ld_reg[i] <= LD_IDLE;
                lo_byte_reg[i] <= RESET_BYTE;
                load_val_reg[i] <= '0;
            end
            rate_reg <= 2'h0;
            load_reg <= 2'h0;
        end else begin
            load_reg <= 2'h0;
            for (int i = 0; i < 2; i++) begin
                if (is_wr(bus_req, ADDR_CTRL)
                        && bus_req.wdata[CTRL_SEL_BIT +: 2] == 2'(i)) begin
                    ld_reg[i] <= LD_LOW;
                    rate_reg[i] <= bus_req.wdata[CTRL_MODE_BIT];
                end else if (is_wr(bus_req, A_CNT[i])) begin
                    unique case (ld_reg[i])
                        LD_IDLE: ld_reg[i] <= LD_IDLE;
                        LD_LOW: begin
                            lo_byte_reg[i] <= bus_req.wdata;
                            ld_reg[i] <= LD_HIGH;
                        end
                        LD_HIGH: begin
                            load_val_reg[i] <= clamp_count({bus_req.wdata,
                                                            lo_byte_reg[i]});
                            load_reg[i] <= 1'b1;
                            ld_reg[i] <= LD_LOW;
                        end
                        default: ld_reg[i] <= LD_IDLE;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // the two counters

    generate
        for (gi = 0; gi < 2; gi++) begin : g_cnt
            ctg_down_counter #(
                .W(COUNT_W)
            ) u_cnt (
                .clk(clk),
                .rst(rst),
                .tick(tick[gi]),
                .gate(gate[gi]),
                .load(load_reg[gi]),
                .load_val(load_val_reg[gi]),
                .rate_mode(rate_reg[gi]),
                .count(cnt_val[gi]),
                .out(cnt_out[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // output routing and interrupt flags

    always_ff @(posedge clk) begin
        if (rst) begin
            out_dly_reg <= 2'h0;
            iso_out_reg <= 2'h0;
        end else begin
            out_dly_reg <= cnt_out;
            for (int i = 0; i < 2; i++) begin
                iso_out_reg[i] <= set_reg[i].out_route & cnt_out[i];
            end
        end
    end

    assign out_rise = cnt_out & ~out_dly_reg;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            irq_set[i] = out_rise[i] & set_reg[i].irq_enable;
        end
    end

    // a set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (irq_set[i]) begin
                    flag_reg[i] <= 1'b1;
                end else if (is_wr(bus_req, ADDR_IRQ) && bus_req.wdata[F_BIT[i]]) begin
                    flag_reg[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port

    // count reads alternate low byte then high byte
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_hi_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (is_wr(bus_req, ADDR_CTRL)) begin
                    rd_hi_reg[i] <= 1'b0;
                end else if (bus_req.rd && bus_req.addr == A_CNT[i]) begin
                    rd_hi_reg[i] <= ~rd_hi_reg[i];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !bus_req.rd) begin
            rdata_reg <= RESET_BYTE;
        end else begin
            rdata_reg <= RESET_BYTE;
            unique case (bus_req.addr)
                ADDR_IRQ: begin
                    rdata_reg[IRQ_F0_BIT] <= flag_reg[0];
                    rdata_reg[IRQ_F1_BIT] <= flag_reg[1];
                end
                ADDR_CNT0: rdata_reg <= rd_hi_reg[0] ? cnt_val[0][15:8] : cnt_val[0][7:0];
                ADDR_CNT1: rdata_reg <= rd_hi_reg[1] ? cnt_val[1][15:8] : cnt_val[1][7:0];
                ADDR_GATE0: begin
                    rdata_reg[OUT_BIT] <= cnt_out[0];
                    rdata_reg[GATE_BIT] <= gate_bit_reg[0];
                end
                ADDR_GATE1: begin
                    rdata_reg[OUT_BIT] <= cnt_out[1];
                    rdata_reg[GATE_BIT] <= gate_bit_reg[1];
                end
                ADDR_SET0: rdata_reg[3:0] <= set_reg[0];
                ADDR_SET1: begin
                    rdata_reg[3:0] <= set_reg[1];
                    rdata_reg[TB_HIGH_BIT:TB_LOW_BIT] <= tb_reg;
                    rdata_reg[CASCADE_BIT] <= cascade_reg;
                end
                default: rdata_reg <= RESET_BYTE;
            endcase
        end
    end

    assign rdata = rdata_reg;
    assign isolated_output_2 = iso_out_reg[0];
    assign isolated_output_3 = iso_out_reg[1];
    assign counter_irq = flag_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_ext_clk0: assert property (@(posedge clk) disable iff (rst)
        (set_reg[0].clock_select && in_rise[1]) |-> tick[0])
        else $error("counter 0 missed a field clock edge");
    a_ext_clk1: assert property (@(posedge clk) disable iff (rst)
        (!cascade_reg && set_reg[1].clock_select && !in_rise[3]) |-> !tick[1])
        else $error("counter 1 ticked without a field clock edge");
    a_tb_spacing: assert property (@(posedge clk) disable iff (rst)
        (tb_tick && tb_reg == TB_100K && !is_wr(bus_req, ADDR_SET1))
        |=> (!tb_tick)[*8])
        else $error("time base ticks too close together");
    a_sw_gate0: assert property (@(posedge clk) disable iff (rst)
        (is_wr(bus_req, ADDR_GATE0) && !set_reg[0].gate_select
            && bus_req.wdata[GATE_BIT]) |=> gate[0])
        else $error("software gate 0 not applied");
    a_field_gate1: assert property (@(posedge clk) disable iff (rst)
        (set_reg[1].gate_select && $rose(in_lvl[2])) |-> gate[1])
        else $error("field gate 1 not applied");
    a_route_out: assert property (@(posedge clk) disable iff (rst)
        set_reg[0].out_route |=> isolated_output_2 == $past(cnt_out[0]))
        else $error("routed counter 0 output not on field output");
    a_route_off: assert property (@(posedge clk) disable iff (rst)
        !set_reg[1].out_route |=> !isolated_output_3)
        else $error("unrouted counter 1 output reached field output");
    a_flag_clear: assert property (@(posedge clk) disable iff (rst)
        (is_wr(bus_req, ADDR_IRQ) && bus_req.wdata[IRQ_F0_BIT] && !irq_set[0])
        |=> !flag_reg[0])
        else $error("flag 0 not cleared by write of one");
    a_flag_set: assert property (@(posedge clk) disable iff (rst)
        irq_set[1] |=> flag_reg[1] ##1 (flag_reg[1] || $past(bus_req.wr)))
        else $error("flag 1 not set by counter event");
    a_irq_quiet: assert property (@(posedge clk) disable iff (rst)
        (!set_reg[0].irq_enable && !flag_reg[0]) |=> !flag_reg[0])
        else $error("flag 0 set while disabled");
    a_cascade: assert property (@(posedge clk) disable iff (rst)
        (cascade_reg && $rose(cnt_out[0]) && gate[1] && !rate_reg[1] && !load_reg[1]
            && cnt_val[1] != '0) |=> cnt_val[1] == $past(cnt_val[1]) - COUNT_W'(1))
        else $error("cascade did not clock counter 1");
    a_load_min: assert property (@(posedge clk) disable iff (rst)
        load_reg[0] |-> load_val_reg[0] >= MIN_COUNT ##1 cnt_val[0] >= MIN_COUNT)
        else $error("counter loaded below the least count");
    a_out_status: assert property (@(posedge clk) disable iff (rst)
        (bus_req.rd && bus_req.addr == ADDR_GATE1)
        |=> rdata[OUT_BIT] == $past(cnt_out[1]))
        else $error("output status does not show counter 1 output");
endmodule
`default_nettype wire

// ---- rtl/ctg_pkg.sv ----
// constants, types and register map for the counter routing glue
package ctg_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TB_100K_HZ = 100_000;
    localparam int unsigned TB_10K_HZ = 10_000;
    localparam int unsigned TB_1K_HZ = 1_000;
    localparam int unsigned TB_100_HZ = 100;
    localparam int unsigned PRE_W = 20;
    localparam int unsigned COUNT_W = 16;
    localparam logic [COUNT_W-1:0] MIN_COUNT = 16'h0002;
    localparam logic [7:0] ADDR_IRQ = 8'h07;
    localparam logic [7:0] ADDR_CNT0 = 8'h08;
    localparam logic [7:0] ADDR_CNT1 = 8'h09;
    localparam logic [7:0] ADDR_CTRL = 8'h0b;
    localparam logic [7:0] ADDR_GATE0 = 8'h0c;
    localparam logic [7:0] ADDR_GATE1 = 8'h0d;
    localparam logic [7:0] ADDR_SET0 = 8'h0e;
    localparam logic [7:0] ADDR_SET1 = 8'h0f;
    localparam int unsigned IRQ_F0_BIT = 2;
    localparam int unsigned IRQ_F1_BIT = 3;
    localparam int unsigned GATE_BIT = 0;
    localparam int unsigned OUT_BIT = 4;
    localparam int unsigned TB_LOW_BIT = 4;
    localparam int unsigned TB_HIGH_BIT = 5;
    localparam int unsigned CASCADE_BIT = 6;
    localparam int unsigned CTRL_SEL_BIT = 6;
    localparam int unsigned CTRL_MODE_BIT = 1;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef enum logic [1:0] {
        TB_100K = 2'h0,
        TB_10K = 2'h1,
        TB_1K = 2'h2,
        TB_100 = 2'h3
    } ctg_tb_t;

    // count loading walks low byte then high byte
    typedef enum logic [2:0] {
        LD_IDLE = 3'h1,
        LD_LOW = 3'h2,
        LD_HIGH = 3'h4
    } ctg_ld_t;

    // field order matches the setting register bits 3..0
    typedef struct packed {
        logic irq_enable;
        logic out_route;
        logic gate_select;
        logic clock_select;
    } ctg_set_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ctg_bus_t;
endpackage

// ---- rtl/ctg_in_sync.sv ----
// three-stage synchroniser with agreement filter for one field input
`timescale 1ns/1ps
`default_nettype none
module ctg_in_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic level,
    output logic rise
);
    logic [2:0] stage_reg;
    logic level_reg;
    logic rise_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage_reg <= 3'h0;
        end else begin
            stage_reg <= {stage_reg[1:0], pin};
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (rst) begin
            level_reg <= 1'b0;
            rise_reg <= 1'b0;
        end else begin
            rise_reg <= 1'b0;
            if (stage_reg[1] == stage_reg[2]) begin
                level_reg <= stage_reg[2];
                rise_reg <= stage_reg[2] & ~level_reg;
            end
        end
    end

    assign level = level_reg;
    assign rise = rise_reg;
endmodule
`default_nettype wire

// ---- rtl/ctg_down_counter.sv ----
// one 16-bit down counter with terminal-count and rate modes
`timescale 1ns/1ps
`default_nettype none
module ctg_down_counter #(
    parameter int unsigned W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic gate,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic rate_mode,
    output logic [W-1:0] count,
    output logic out
);
    logic [W-1:0] count_reg;
    logic [W-1:0] reload_reg;
    logic out_reg;
    logic armed_reg;
    logic rate_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= '0;
            reload_reg <= '0;
            out_reg <= 1'b0;
            armed_reg <= 1'b0;
            rate_reg <= 1'b0;
        end else if (load) begin
            count_reg <= load_val;
            reload_reg <= load_val;
            out_reg <= rate_mode;
            armed_reg <= 1'b1;
            rate_reg <= rate_mode;
        end else if (armed_reg && tick && gate) begin
            if (rate_reg) begin
                // low for one tick when the count reaches one
                if (count_reg == W'(1)) begin
                    count_reg <= reload_reg;
                    out_reg <= 1'b1;
                end else begin
                    count_reg <= count_reg - W'(1);
                    out_reg <= (count_reg != W'(2));
                end
            end else if (count_reg != '0) begin
                count_reg <= count_reg - W'(1);
                if (count_reg == W'(1)) begin
                    out_reg <= 1'b1;
                end
            end
        end
    end

    assign count = count_reg;
    assign out = out_reg;
endmodule
`default_nettype wire

// ---- verif/ctg_field_model.sv ----
// field side model: drives the isolated clock and gate inputs
`timescale 1ns/1ps
`default_nettype none
module ctg_field_model (
    input wire logic clk,
    output logic [3:0] isolated_input
);
    initial begin
        isolated_input = 4'h0;
    end
    ////////////////////////////////////////////////////////////////
    // levels move right after an edge and stay far longer than the input filter needs
    task automatic set_pin(input int idx, input logic v);
        @(posedge clk);
        isolated_input[idx] <= v;
    endtask
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            @(posedge clk);
            isolated_input[idx] <= 1'b1;
            repeat (20) @(posedge clk);
            isolated_input[idx] <= 1'b0;
            repeat (20) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ---- verif/ctg_top_tb_top.sv ----
// self-checking bench for the counter routing glue
`timescale 1ns/1ps
`default_nettype none
module ctg_top_tb_top;
    import ctg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    ctg_bus_t bus_req = '0;
    logic [7:0] rdata;
    logic [3:0] isolated_input;
    logic isolated_output_2;
    logic isolated_output_3;
    logic [1:0] counter_irq;
    int err_count = 0;
    int n_tests = 0;
    always #5 clk = ~clk;
    ctg_top #(.DIV_100K(10), .DIV_10K(20), .DIV_1K(40), .DIV_100(80)) ctg_top_i (
        .clk(clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
        .isolated_input(isolated_input), .isolated_output_2(isolated_output_2),
        .isolated_output_3(isolated_output_3), .counter_irq(counter_irq));
    ctg_field_model ctg_field_model_i (.clk(clk), .isolated_input(isolated_input));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] d;
        rd(ADDR_SET0, d);
        chk("set0", 8'h00, d);
        rd(ADDR_SET1, d);
        chk("set1", 8'h00, d);
        rd(ADDR_IRQ, d);
        chk("flags", 8'h00, d);
        wr(8'h0a, 8'hff);
        rd(8'h0a, d);
        chk("unmapped", 8'h00, d);
        chk("pins", 8'h00, {4'h0, isolated_output_3, isolated_output_2, counter_irq});
        $display("test reset done");
    endtask
    task automatic t_irq();
        logic [7:0] d;
        int n;
        wr(ADDR_SET0, 8'h08);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_CNT0, 8'h05);
        wr(ADDR_CNT0, 8'h00);
        wr(ADDR_GATE0, 8'h01);
        rd(ADDR_GATE0, d);
        chk("gate0 early", 8'h01, d);
        n = 0;
        while (counter_irq[0] !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        chk("irq0 line", 8'h01, {7'h0, counter_irq[0]});
        rd(ADDR_GATE0, d);
        chk("out0 status", 8'h11, d);
        rd(ADDR_IRQ, d);
        chk("flag0 set", 8'h04, d);
        wr(ADDR_IRQ, 8'h00);
        rd(ADDR_IRQ, d);
        chk("flag0 after 0", 8'h04, d);
        wr(ADDR_IRQ, 8'h04);
        rd(ADDR_IRQ, d);
        chk("flag0 cleared", 8'h00, d);
        chk("out2 unrouted", 8'h00, {7'h0, isolated_output_2});
        wr(ADDR_SET0, 8'h0c);
        repeat (3) @(posedge clk);
        #1 chk("out2 routed", 8'h01, {7'h0, isolated_output_2});
        $display("test irq done");
    endtask
    task automatic t_timebase();
        int n;
        int div;
        for (int tb = 0; tb < 4; tb++) begin
            div = 10 << tb;
            wr(ADDR_SET1, 8'(tb << TB_LOW_BIT));
            wr(ADDR_IRQ, 8'h04);
            wr(ADDR_CTRL, 8'h00);
            wr(ADDR_CNT0, 8'h04);
            wr(ADDR_CNT0, 8'h00);
            n = 0;
            while (counter_irq[0] !== 1'b1 && n < 1000) begin
                @(posedge clk);
                n++;
            end
            chk("tick span", 8'h01, {7'h0, (n >= 3 * div && n <= 4 * div + 8)});
        end
        $display("test timebase done");
    endtask
    task automatic t_ext();
        logic [7:0] d;
        wr(ADDR_SET1, 8'h03);
        wr(ADDR_CTRL, 8'h40);
        wr(ADDR_CNT1, 8'h03);
        wr(ADDR_CNT1, 8'h00);
        ctg_field_model_i.set_pin(2, 1'b1);
        ctg_field_model_i.pulse(3, 2);
        rd(ADDR_GATE1, d);
        chk("out1 after 2", 8'h00, d);
        ctg_field_model_i.pulse(3, 1);
        rd(ADDR_GATE1, d);
        chk("out1 after 3", 8'h10, d);
        chk("irq1 masked", 8'h00, {7'h0, counter_irq[1]});
        chk("out3 unrouted", 8'h00, {7'h0, isolated_output_3});
        wr(ADDR_SET1, 8'h07);
        repeat (3) @(posedge clk);
        #1 chk("out3 routed", 8'h01, {7'h0, isolated_output_3});
        $display("test external done");
    endtask
    task automatic t_cascade();
        logic [7:0] d;
        wr(ADDR_SET0, 8'h03);
        wr(ADDR_SET1, 8'h48);
        wr(ADDR_GATE1, 8'h01);
        wr(ADDR_CTRL, 8'h02);
        wr(ADDR_CNT0, 8'h02);
        wr(ADDR_CNT0, 8'h00);
        wr(ADDR_CTRL, 8'h40);
        wr(ADDR_CNT1, 8'h02);
        wr(ADDR_CNT1, 8'h00);
        ctg_field_model_i.set_pin(0, 1'b1);
        ctg_field_model_i.pulse(1, 2);
        rd(ADDR_CNT0, d);
        chk("cnt0 low", 8'h02, d);
        @(posedge clk);
        #1 chk("rdata idle", 8'h00, rdata);
        rd(ADDR_CNT0, d);
        chk("cnt0 high", 8'h00, d);
        rd(ADDR_GATE1, d);
        chk("out1 half", 8'h01, d);
        ctg_field_model_i.pulse(1, 2);
        rd(ADDR_GATE1, d);
        chk("out1 cascaded", 8'h11, d);
        rd(ADDR_IRQ, d);
        chk("flags both", 8'h0c, d);
        wr(ADDR_IRQ, 8'h08);
        rd(ADDR_IRQ, d);
        chk("flag1 cleared", 8'h04, d);
        $display("test cascade done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #200_000;
        err_count++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_irq();
        t_timebase();
        t_ext();
        t_cascade();
        close_out();
    end
endmodule
`default_nettype wire
